// >>> rtl/presignal_cfg.svh
// Constants for the presignal detector and bit-pair aligner
`ifndef PRESIGNAL_CFG_SVH
`define PRESIGNAL_CFG_SVH

// System clock period
`define CLK_PERIOD_NS    40
// Hold-off time and its cycle count, rounded up
`define HOLDOFF_TIME_MS  9.33
`define HOLDOFF_CYCLES   (int'($ceil(`HOLDOFF_TIME_MS * 1.0e6 / `CLK_PERIOD_NS)))
`define HOLD_CNT_W       18

// Tone detector window and its two alternating patterns
`define TONE_LEN         16
`define TONE_PAT_A       16'haaaa
`define TONE_PAT_B       16'h5555

// Tail window: last index of a 15-bit window, matches needed
`define WIN_LAST         4'he
`define MATCH_MIN        4'h8

// Pair buffer
`define PAIR_W           2
`define FIFO_DEPTH       32

// Pin synchroniser lanes
`define SYNC_W           4
`define PIN_DD           0
`define PIN_DL           1
`define PIN_CLK12        2
`define PIN_DATA         3

`endif

// >>> rtl/presignal_pkg.sv
// Types shared by the presignal aligner
package presignal_pkg;

  typedef enum logic [1:0] {
    HOLD_IDLE  = 2'b00,
    HOLD_WAIT  = 2'b01,
    HOLD_COUNT = 2'b10,
    HOLD_TERM  = 2'b11
  } hold_state_type;

  typedef enum logic [2:0] {
    DET_OFF  = 3'b000,
    DET_SEEK = 3'b001,
    DET_ARM  = 3'b010,
    DET_TAIL = 3'b011,
    DET_DONE = 3'b100
  } det_state_type;

endpackage

// >>> rtl/pair_stream_if.sv
// Valid/ready carrier for bit pairs between the aligner and its buffer
`include "presignal_cfg.svh"
interface pair_stream_if;
  logic               valid;
  logic               ready;
  logic [`PAIR_W-1:0] data;
  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface

// >>> rtl/pin_sync.sv
// Three-stage pin synchroniser with a two-stage agreement filter
module pin_sync #(
  parameter int W = 4
) (
  input  wire logic         clk_sys_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] sig_i,
  output logic      [W-1:0] sig_o
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] filt_reg;
  logic [W-1:0] filt_next;

  // Output follows only when the second and third stages agree
  for (genvar g = 0; g < W; g++) begin : g_lane
    always_comb begin
      filt_next[g] = (s2_reg[g] == s3_reg[g]) ? s3_reg[g] : filt_reg[g];
    end
  end

  // Shift chain and filter register
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      s1_reg   <= '0;
      s2_reg   <= '0;
      s3_reg   <= '0;
      filt_reg <= '0;
    end else if (ce_i) begin
      s1_reg   <= sig_i;
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
      filt_reg <= filt_next;
    end
  end

  assign sig_o = filt_reg;

endmodule

// >>> rtl/pair_fifo.sv
// Bit-pair FIFO with registered read data
`include "presignal_cfg.svh"
module pair_fifo #(
  parameter int W     = `PAIR_W,
  parameter int DEPTH = `FIFO_DEPTH
) (
  input  wire logic   clk_sys_i,
  input  wire logic   rst_i,
  input  wire logic   ce_i,
  pair_stream_if.sink   wr,
  pair_stream_if.source rd
);

  localparam int          AW   = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wptr_reg, wptr_next, rptr_reg, rptr_next;
  logic [AW:0]   count_reg, count_next;
  logic [W-1:0]  out_reg, out_next;
  logic          out_valid_reg, out_valid_next;
  logic          push, load;

  // Push when not full, refill the output register when it frees up
  always_comb begin
    push           = wr.valid && (count_reg != FULL);
    load           = (count_reg != '0) && (!out_valid_reg || rd.ready);
    wptr_next      = push ? wptr_reg + 1'b1 : wptr_reg;
    rptr_next      = load ? rptr_reg + 1'b1 : rptr_reg;
    count_next     = count_reg + (AW + 1)'(push) - (AW + 1)'(load);
    out_next       = load ? mem[rptr_reg] : out_reg;
    out_valid_next = load || (out_valid_reg && !rd.ready);
  end

  // State registers and storage
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      wptr_reg      <= '0;
      rptr_reg      <= '0;
      count_reg     <= '0;
      out_reg       <= '0;
      out_valid_reg <= 1'b0;
    end else if (ce_i) begin
      wptr_reg      <= wptr_next;
      rptr_reg      <= rptr_next;
      count_reg     <= count_next;
      out_reg       <= out_next;
      out_valid_reg <= out_valid_next;
      if (push) begin
        mem[wptr_reg] <= wr.data;
      end
    end
  end

  assign wr.ready = (count_reg != FULL);
  assign rd.valid = out_valid_reg;
  assign rd.data  = out_reg;

endmodule

// >>> rtl/presignal_dibit_aligner.sv
// Presignal detector and bit-pair aligner for the delay module
// How it works
// - Data detect low holds hold-off counter cleared
// - Detect high plus pulse starts hold-off count
// - Count reaches maximum, terminal set, counting stops
// - Terminal enables tone detector while detect high
// - Divide recovered 12 kHz clock by two
// - Tone detect samples divider into phase flag
// - Symbol clock is divider XOR phase flag
// - Group incoming bits into ordered pairs
// - Present pair bits on two symbol outputs
// - Arm tail search on next 12 kHz fall
// - Local tone reference XOR data flags mismatches
// - Mismatches count; window clears count every 15
// - Eight of fifteen inverted bits latch detect
// - Detect latch drives tail-detected output high
// - Tail output low until presignal complete
// - Data detect enables all presignal logic except the divider and symbol clock
`include "presignal_cfg.svh"
module presignal_dibit_aligner #(
  parameter int unsigned HOLDOFF_CYCLES = `HOLDOFF_CYCLES
) (
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  input  wire logic ext_data_detect_i,
  input  wire logic delay_latched_pulse_n_i,
  input  wire logic clk_12k_i,
  input  wire logic rx_data_i,
  input  wire logic encoder_ready_i,
  output logic      data_detect_to_cpu_o,
  output logic      symbol_clk_o,
  output logic      symbol_bit_first_o,
  output logic      symbol_bit_second_o,
  output logic      tail_detected_o,
  output logic      scope_trigger_out_o,
  output logic      overrun_o
);

  localparam logic [`HOLD_CNT_W-1:0] HOLD_LAST =
    `HOLD_CNT_W'(HOLDOFF_CYCLES - 1);

  logic [`SYNC_W-1:0]          pins_raw;
  logic [`SYNC_W-1:0]          pins_s;
  logic                        dd_s;
  logic                        dl_n_s;
  logic                        clk12_s;
  logic                        data_s;
  logic                        clk12_prev_reg;
  logic                        dl_prev_reg;
  logic                        clk12_rise;
  logic                        clk12_fall;
  logic                        dl_fall;
  presignal_pkg::hold_state_type hold_state_reg;
  presignal_pkg::hold_state_type hold_state_next;
  logic [`HOLD_CNT_W-1:0]      hold_cnt_reg;
  logic [`HOLD_CNT_W-1:0]      hold_cnt_next;
  logic                        terminal;
  presignal_pkg::det_state_type det_state_reg;
  presignal_pkg::det_state_type det_state_next;
  logic [`TONE_LEN-1:0]        tone_sr_reg;
  logic [`TONE_LEN-1:0]        tone_sr_next;
  logic [`TONE_LEN-1:0]        tone_sr_shift;
  logic                        phase_reg;
  logic                        phase_next;
  logic                        ref_reg;
  logic                        ref_next;
  logic [3:0]                  win_reg;
  logic [3:0]                  win_next;
  logic [3:0]                  match_reg;
  logic [3:0]                  match_next;
  logic [3:0]                  match_sum;
  logic                        mism;
  logic                        tone_hit;
  logic                        aligned;
  logic                        slot;
  logic                        div_reg;
  logic                        div_next;
  logic                        first_reg;
  logic                        first_next;
  logic                        pend_reg;
  logic                        pend_next;
  logic [`PAIR_W-1:0]          pair_reg;
  logic [`PAIR_W-1:0]          pair_next;
  logic                        overrun_reg;
  logic                        overrun_next;
  logic                        sym_rise;
  logic                        pop;
  logic                        sym_clk_next;
  logic                        bit_first_next;
  logic                        bit_second_next;
  logic                        tail_next;

  pair_stream_if fill_if ();
  pair_stream_if drain_if ();

  // Pin lanes into the synchroniser
  assign pins_raw = {rx_data_i, clk_12k_i, delay_latched_pulse_n_i,
                     ext_data_detect_i};
  assign dd_s     = pins_s[`PIN_DD];
  assign dl_n_s   = pins_s[`PIN_DL];
  assign clk12_s  = pins_s[`PIN_CLK12];
  assign data_s   = pins_s[`PIN_DATA];

  pin_sync #(
    .W (`SYNC_W)
  ) u_sync (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .sig_i     (pins_raw),
    .sig_o     (pins_s)
  );

  // Edges of the recovered clock and of the delay-latched pulse
  assign clk12_rise = clk12_s && !clk12_prev_reg;
  assign clk12_fall = !clk12_s && clk12_prev_reg;
  assign dl_fall    = !dl_n_s && dl_prev_reg;
  assign terminal   = (hold_state_reg == presignal_pkg::HOLD_TERM);

  // Hold-off timer
  always_comb begin
    hold_state_next = hold_state_reg;
    hold_cnt_next   = hold_cnt_reg;
    case (hold_state_reg)
      presignal_pkg::HOLD_IDLE: begin
        hold_cnt_next = '0;
        if (dd_s) begin
          hold_state_next = presignal_pkg::HOLD_WAIT;
        end
      end
      presignal_pkg::HOLD_WAIT: begin
        if (dl_fall) begin
          hold_state_next = presignal_pkg::HOLD_COUNT;
        end
      end
      presignal_pkg::HOLD_COUNT: begin
        if (hold_cnt_reg == HOLD_LAST) begin
          hold_state_next = presignal_pkg::HOLD_TERM;
        end else begin
          hold_cnt_next = hold_cnt_reg + 1'b1;
        end
      end
      presignal_pkg::HOLD_TERM: begin
        hold_state_next = presignal_pkg::HOLD_TERM;
      end
      default: begin
        hold_state_next = presignal_pkg::HOLD_IDLE;
      end
    endcase
    // Detect low keeps the timer cleared
    if (!dd_s) begin
      hold_state_next = presignal_pkg::HOLD_IDLE;
      hold_cnt_next   = '0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      hold_state_reg <= presignal_pkg::HOLD_IDLE;
      hold_cnt_reg   <= '0;
      clk12_prev_reg <= 1'b0;
      dl_prev_reg    <= 1'b0; // Same level as the synchroniser after reset
    end else if (ce_i) begin
      hold_state_reg <= hold_state_next;
      hold_cnt_reg   <= hold_cnt_next;
      clk12_prev_reg <= clk12_s;
      dl_prev_reg    <= dl_n_s;
    end
  end

  // Tone search, phase choice and tail detection
  always_comb begin
    det_state_next = det_state_reg;
    tone_sr_next   = tone_sr_reg;
    phase_next     = phase_reg;
    ref_next       = ref_reg;
    win_next       = win_reg;
    match_next     = match_reg;
    tone_hit       = 1'b0;
    tone_sr_shift  = {tone_sr_reg[`TONE_LEN-2:0], data_s};
    mism           = data_s ^ ref_reg;
    match_sum      = match_reg + {3'h0, mism};
    case (det_state_reg)
      presignal_pkg::DET_OFF: begin
        if (terminal) begin
          det_state_next = presignal_pkg::DET_SEEK;
        end
      end
      presignal_pkg::DET_SEEK: begin
        if (clk12_rise && terminal) begin
          tone_sr_next = tone_sr_shift;
          if (tone_sr_shift == `TONE_PAT_A ||
              tone_sr_shift == `TONE_PAT_B) begin
            tone_hit       = 1'b1;
            phase_next     = div_reg;
            ref_next       = !data_s;
            det_state_next = presignal_pkg::DET_ARM;
          end
        end
      end
      presignal_pkg::DET_ARM: begin
        if (clk12_fall) begin
          det_state_next = presignal_pkg::DET_TAIL;
          win_next       = '0;
          match_next     = '0;
        end
      end
      presignal_pkg::DET_TAIL: begin
        if (clk12_rise) begin
          ref_next = !ref_reg;
          if (match_sum >= `MATCH_MIN) begin
            det_state_next = presignal_pkg::DET_DONE;
          end else if (win_reg == `WIN_LAST) begin
            win_next   = '0;
            match_next = '0;
          end else begin
            win_next   = win_reg + 4'h1;
            match_next = match_sum;
          end
        end
      end
      presignal_pkg::DET_DONE: begin
        det_state_next = presignal_pkg::DET_DONE;
      end
      default: begin
        det_state_next = presignal_pkg::DET_OFF;
      end
    endcase
    // Without the terminal signal all detection state is cleared
    if (!terminal) begin
      det_state_next = presignal_pkg::DET_OFF;
      tone_sr_next   = '0;
      phase_next     = 1'b0;
      ref_next       = 1'b0;
      win_next       = '0;
      match_next     = '0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      det_state_reg <= presignal_pkg::DET_OFF;
      tone_sr_reg   <= '0;
      phase_reg     <= 1'b0;
      ref_reg       <= 1'b0;
      win_reg       <= '0;
      match_reg     <= '0;
    end else if (ce_i) begin
      det_state_reg <= det_state_next;
      tone_sr_reg   <= tone_sr_next;
      phase_reg     <= phase_next;
      ref_reg       <= ref_next;
      win_reg       <= win_next;
      match_reg     <= match_next;
    end
  end

  // Divider and pairing; slot 1 carries the first bit of a pair
  assign aligned = (det_state_reg != presignal_pkg::DET_OFF) &&
                   (det_state_reg != presignal_pkg::DET_SEEK);
  assign slot    = div_reg ^ phase_reg;

  always_comb begin
    div_next     = clk12_rise ? !div_reg : div_reg;
    first_next   = first_reg;
    pair_next    = pair_reg;
    pend_next    = pend_reg && !fill_if.ready;
    overrun_next = overrun_reg;
    if (aligned && clk12_rise) begin
      if (slot) begin
        first_next = data_s;
      end else if (pend_next) begin
        overrun_next = 1'b1;
      end else begin
        pair_next = {first_reg, data_s};
        pend_next = 1'b1;
      end
    end
    if (!dd_s) begin
      pend_next    = 1'b0;
      overrun_next = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      div_reg     <= 1'b0;
      first_reg   <= 1'b0;
      pair_reg    <= '0;
      pend_reg    <= 1'b0;
      overrun_reg <= 1'b0;
    end else if (ce_i) begin
      div_reg     <= div_next;
      first_reg   <= first_next;
      pair_reg    <= pair_next;
      pend_reg    <= pend_next;
      overrun_reg <= overrun_next;
    end
  end

  assign fill_if.valid = pend_reg;
  assign fill_if.data  = pair_reg;

  pair_fifo #(
    .W     (`PAIR_W),
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .wr        (fill_if),
    .rd        (drain_if)
  );

  // Output stage: one pair leaves on a symbol clock rise when a pair is waiting and the encoder is ready
  assign sym_rise       = slot && !symbol_clk_o;
  assign drain_if.ready = aligned && sym_rise && encoder_ready_i;
  assign pop            = drain_if.valid && drain_if.ready;

  always_comb begin
    sym_clk_next    = slot;
    bit_first_next  = pop ? drain_if.data[1] : symbol_bit_first_o;
    bit_second_next = pop ? drain_if.data[0] : symbol_bit_second_o;
    tail_next       = (det_state_next == presignal_pkg::DET_DONE);
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      data_detect_to_cpu_o <= 1'b0;
      symbol_clk_o         <= 1'b0;
      symbol_bit_first_o   <= 1'b0;
      symbol_bit_second_o  <= 1'b0;
      tail_detected_o      <= 1'b0;
      scope_trigger_out_o  <= 1'b0;
      overrun_o            <= 1'b0;
    end else if (ce_i) begin
      data_detect_to_cpu_o <= dd_s;
      symbol_clk_o         <= sym_clk_next;
      symbol_bit_first_o   <= bit_first_next;
      symbol_bit_second_o  <= bit_second_next;
      tail_detected_o      <= tail_next;
      scope_trigger_out_o  <= tone_hit;
      overrun_o            <= overrun_next;
    end
  end

  // Checks on the running logic
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i || !ce_i);

  a_holdoff_idle: assert property (!dd_s |=> hold_cnt_reg == '0)
    else $error("Hold-off counter not cleared while detect low");
  a_count_start: assert property (
    hold_state_reg == presignal_pkg::HOLD_WAIT && dl_fall && dd_s
    |=> hold_state_reg == presignal_pkg::HOLD_COUNT && hold_cnt_reg == '0)
    else $error("Hold-off count did not start on latched pulse");
  a_terminal_time: assert property (
    $rose(terminal) |-> $past(hold_cnt_reg) == HOLD_LAST)
    else $error("Terminal raised at wrong count");
  a_terminal_stays: assert property (
    terminal && dd_s |=> terminal && $stable(hold_cnt_reg))
    else $error("Terminal dropped while detect high");
  a_divider_toggle: assert property (
    clk12_rise |=> div_reg != $past(div_reg))
    else $error("Divider missed a recovered clock edge");
  a_phase_sample: assert property (tone_hit |=> phase_reg == $past(div_reg))
    else $error("Phase flag not taken from divider");
  a_symbol_clock: assert property (
    ##1 symbol_clk_o == $past(div_reg ^ phase_reg))
    else $error("Symbol clock not divider xor phase");
  a_pair_form: assert property (
    aligned && clk12_rise && !slot && !(pend_reg && !fill_if.ready) && dd_s
    |=> pend_reg && pair_reg == {$past(first_reg), $past(data_s)})
    else $error("Bit pair not formed in order");
  a_pair_output: assert property (
    pop |=> symbol_bit_first_o == $past(drain_if.data[1]) &&
            symbol_bit_second_o == $past(drain_if.data[0]))
    else $error("Symbol bits do not match popped pair");
  a_arm_fall: assert property (
    det_state_reg == presignal_pkg::DET_ARM && clk12_fall && terminal
    |=> det_state_reg == presignal_pkg::DET_TAIL)
    else $error("Tail search not armed on falling edge");
  a_window_clear: assert property (
    det_state_reg == presignal_pkg::DET_TAIL && clk12_rise && terminal &&
    win_reg == `WIN_LAST && match_sum < `MATCH_MIN
    |=> win_reg == '0 && match_reg == '0)
    else $error("Match counter not cleared at window end");
  a_tail_latch: assert property (
    det_state_reg == presignal_pkg::DET_TAIL && clk12_rise && terminal &&
    match_sum >= `MATCH_MIN |=> tail_detected_o)
    else $error("Tail not latched after eight matches");
  a_tail_quiet: assert property (
    det_state_reg != presignal_pkg::DET_DONE |-> !tail_detected_o)
    else $error("Tail output high before tail detected");
  a_detect_drop: assert property (
    !dd_s |-> ##2 !tail_detected_o && !phase_reg && match_reg == '0)
    else $error("State not cleared after detect fell");

  c_terminal: cover property ($rose(terminal));
  c_tone: cover property (tone_hit);
  c_tail: cover property ($rose(tail_detected_o));
  c_pop: cover property (pop ##[1:3] !drain_if.valid);

endmodule

// >>> test/host_cpu_model.sv
// Host processor and symbol encoder stand-in facing the aligner
module host_cpu_model #(
  parameter int LATENCY = 8
) (
  input  wire logic clk_sys_i,
  input  wire logic ext_data_detect_i,
  input  wire logic answer_en_i,
  input  wire logic stall_i,
  output logic      delay_latched_pulse_n_o,
  output logic      encoder_ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic detect_d;

  // Answers each detect rise seen while answer_en_i is high with a low pulse once delays are latched
  initial begin
    delay_latched_pulse_n_o = 1'b1;
    detect_d = 1'b0;
    forever begin
      @(negedge clk_sys_i);
      if (ext_data_detect_i && !detect_d && answer_en_i) begin
        repeat (LATENCY) @(negedge clk_sys_i);
        delay_latched_pulse_n_o = 1'b0;
        repeat (4) @(negedge clk_sys_i);
        delay_latched_pulse_n_o = 1'b1;
      end
      detect_d = ext_data_detect_i;
    end
  end

  // Encoder takes symbols unless told to stall
  assign encoder_ready_o = !stall_i;
endmodule

// >>> test/presignal_dibit_aligner_tb.sv
// Self-checking bench for the presignal aligner
module presignal_dibit_aligner_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HOLDOFF = 20;
  localparam int HALF    = 8;
  logic clk_sys_i;
  logic rst_i;
  logic ext_data_detect_i;
  logic clk_12k_i;
  logic rx_data_i;
  logic answer_en;
  logic stall;
  logic dl_n;
  logic enc_ready;
  logic dd_cpu;
  logic sym_clk;
  logic sym_d;
  logic first_bit;
  logic second_bit;
  logic tail;
  logic scope;
  logic overrun;
  int   n_fail;
  int   checked;
  int   n_scope;
  int   n_sym;

  presignal_dibit_aligner #(.HOLDOFF_CYCLES(HOLDOFF)) i_presignal_dibit_aligner (
    .clk_sys_i               (clk_sys_i),
    .rst_i                   (rst_i),
    .ce_i                    (1'b1),
    .ext_data_detect_i       (ext_data_detect_i),
    .delay_latched_pulse_n_i (dl_n),
    .clk_12k_i               (clk_12k_i),
    .rx_data_i               (rx_data_i),
    .encoder_ready_i         (enc_ready),
    .data_detect_to_cpu_o    (dd_cpu),
    .symbol_clk_o            (sym_clk),
    .symbol_bit_first_o      (first_bit),
    .symbol_bit_second_o     (second_bit),
    .tail_detected_o         (tail),
    .scope_trigger_out_o     (scope),
    .overrun_o               (overrun)
  );

  host_cpu_model i_host_cpu_model (
    .clk_sys_i               (clk_sys_i),
    .ext_data_detect_i       (ext_data_detect_i),
    .answer_en_i             (answer_en),
    .stall_i                 (stall),
    .delay_latched_pulse_n_o (dl_n),
    .encoder_ready_o         (enc_ready)
  );

  // System clock, 40 ns period
  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  // Counts tone-hit pulses and symbol clock rises
  always @(posedge clk_sys_i) begin
    if (scope === 1'b1) n_scope++;
    if (sym_clk === 1'b1 && sym_d === 1'b0) n_sym++;
    sym_d <= sym_clk;
  end

  task automatic check(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  // Sends bits first..last: 0 tone, 1 inverted tone, 2 all ones
  task automatic send_run(input int first, input int last, input int mode);
    logic b;
    for (int i = first; i <= last; i++) begin
      b = (mode == 2) ? 1'b1 : ((i % 2 == 0) ^ (mode == 1));
      @(negedge clk_sys_i);
      clk_12k_i = 1'b0;
      rx_data_i = b;
      repeat (HALF) @(negedge clk_sys_i);
      clk_12k_i = 1'b1;
      repeat (HALF - 1) @(negedge clk_sys_i);
    end
  endtask

  task automatic set_detect(input logic v);
    @(negedge clk_sys_i);
    ext_data_detect_i = v;
    repeat (HOLDOFF + 60) @(negedge clk_sys_i);
    check("data_detect_to_cpu", dd_cpu, v);
  endtask

  // Without the latched pulse the hold-off never ends
  task automatic test_no_pulse();
    answer_en = 1'b0;
    n_scope = 0;
    set_detect(1'b1);
    send_run(0, 39, 0);
    check("scope_no_pulse", n_scope, 0);
    check("tail_no_pulse", tail, 0);
    set_detect(1'b0);
    answer_en = 1'b1;
  endtask

  // Full presignal: tone, near miss, inverted tone, data
  // The window starts cleared, so the hit lands on tone bit 14 and
  // pairs of tone read 0 then 1
  task automatic test_presignal();
    n_scope = 0;
    set_detect(1'b1);
    send_run(0, 31, 0);
    check("scope_hits", n_scope, 1);
    check("tone_pair", {first_bit, second_bit}, 2'b01);
    send_run(32, 38, 1);
    send_run(39, 69, 0);
    check("tail_seven", tail, 0);
    check("tone_pair_again", {first_bit, second_bit}, 2'b01);
    send_run(70, 85, 1);
    check("tail_set", tail, 1);
    n_sym = 0;
    send_run(86, 125, 2);
    check("ones_pair", {first_bit, second_bit}, 2'b11);
    check("sym_rate_lo", n_sym >= 19, 1);
    check("sym_rate_hi", n_sym <= 21, 1);
    set_detect(1'b0);
    check("tail_clear", tail, 0);
  endtask

  // Stalled encoder: buffer fills and drops pairs
  task automatic test_overrun();
    set_detect(1'b1);
    send_run(0, 31, 0);
    send_run(32, 49, 1);
    check("tail_rearm", tail, 1);
    stall = 1'b1;
    send_run(50, 139, 2);
    check("overrun_set", overrun, 1);
    stall = 1'b0;
    set_detect(1'b0);
    check("overrun_clear", overrun, 0);
    check("tail_clear2", tail, 0);
  endtask

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    repeat (40000) @(posedge clk_sys_i);
    n_fail++;
    print_verdict();
  end

  // Main sequence
  initial begin
    n_fail = 0;
    checked = 0;
    rst_i = 1'b1;
    ext_data_detect_i = 1'b0;
    clk_12k_i = 1'b1;
    rx_data_i = 1'b0;
    answer_en = 1'b1;
    stall = 1'b0;
    repeat (12) @(negedge clk_sys_i);
    rst_i = 1'b0;
    @(negedge clk_sys_i);
    check("reset_outputs", {first_bit, second_bit, tail, scope, overrun}, 0);
    test_no_pulse();
    test_presignal();
    test_overrun();
    print_verdict();
  end
endmodule
